// [core/ciau_pkg.sv]
// Package: constants and types for the CPU interrupt acceptance unit
package ciau_pkg;
   // ----------------------------------------
   // Vector table
   // ----------------------------------------
   localparam logic [15:0] VEC_BASE     = 16'hFFE0;
   localparam logic [15:0] VEC_RESET    = 16'hFFFE;
   localparam logic [15:0] VEC_NMI      = 16'hFFFC;
   localparam logic [15:0] VEC_WDT      = 16'hFFF4;
   localparam int          NUM_LEVELS   = 16;
   localparam int          LVL_NMI      = 14;
   localparam int          LVL_WDT      = 10;
   localparam int          NUM_MASKABLE = 14;
   // ----------------------------------------
   // Status word bit positions
   // ----------------------------------------
   localparam int          PSW_GIE      = 3;
   localparam int          PSW_CPUHALT  = 4;
   localparam int          PSW_OSCHALT  = 5;
   localparam int          PSW_CLOCK_GATE_ZERO_BIT     = 6;
   localparam int          PSW_CLOCK_GATE_ONE_BIT     = 7;
   localparam logic [15:0] PSW_RESET    = 16'h0000;
   localparam logic [15:0] PC_RESET     = 16'h0000;
   // ----------------------------------------
   // Sequence timing in cycles
   // ----------------------------------------
   localparam logic [2:0]  ACCEPT_CYCLES = 3'd6;
   localparam logic [2:0]  RETURN_CYCLES = 3'd5;
   // ----------------------------------------
   // Sequencer states
   // ----------------------------------------
   typedef enum logic [2:0] {
      ST_RUN    = 3'b001,
      ST_ACCEPT = 3'b010,
      ST_RETURN = 3'b100
   } ciau_state_t;
endpackage

// [core/ciau_top.sv]
// Top module: interrupt gating, priority, acceptance and return sequencing
//
// The implementer's own choices: the strobed register port.
`timescale 1ns/1ps
module ciau_top (
   input  wire logic                 mclk,
   input  wire logic                 rstn,
   // Peripheral maskable requests, level 0..13 (bit 10 unused, watchdog there)
   input  wire logic [13:0]          irq_request,
   input  wire logic [13:0]          irq_enable,
   input  wire logic                 watchdog_event_flag,
   input  wire logic                 watchdog_irq_enable,
   // Non-maskable sources
   input  wire logic                 nmi_pin_mode,
   input  wire logic                 nmi_pin,
   input  wire logic                 pin_edge_select_bit,
   input  wire logic                 osc_fault_flag,
   input  wire logic                 access_violation_flag,
   input  wire logic                 pin_event_flag_clr,
   input  wire logic                 nmi_enable_we,
   input  wire logic [2:0]           nmi_enable_wdata,
   // CPU core side
   input  wire logic                 instr_boundary,
   input  wire logic                 return_from_service_instr,
   input  wire logic [15:0]          next_instr_pc,
   input  wire logic                 psw_we,
   input  wire logic [15:0]          psw_wdata,
   input  wire logic [15:0]          stack_rdata,
   input  wire logic [15:0]          vector_rdata,
   output logic [15:0]               processor_status_word,
   output logic [15:0]               pc,
   output logic                      pc_load,
   output logic                      stack_push,
   output logic                      stack_pop,
   output logic [15:0]               stack_wdata,
   output logic                      vector_fetch,
   output logic [15:0]               vector_addr,
   output logic                      irq_ack,
   output logic [13:0]               irq_clear,
   output logic                      watchdog_flag_clr,
   output logic                      busy,
   output logic                      pin_event_flag,
   output logic                      pin_event_irq_enable,
   output logic                      osc_fault_irq_enable,
   output logic                      access_violation_irq_enable,
   output logic                      global_irq_enable
);
   import ciau_pkg::*;

   ciau_state_t state;
   logic [2:0]  cnt;
   logic [3:0]  sel_level;
   logic        pin_q;
   logic        pin_edge;
   logic [15:0] pending;
   logic        any_pending;
   logic [3:0]  next_level;
   logic        take;

   assign global_irq_enable = processor_status_word[PSW_GIE];
   assign busy              = (state != ST_RUN);

   // ----------------------------------------
   // NMI pin edge and flag
   // ----------------------------------------
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         pin_q <= 1'b1;
      end else begin
         pin_q <= nmi_pin;
      end
   end

   // Edge select high means falling edge
   assign pin_edge = nmi_pin_mode &&
                     (pin_edge_select_bit ? (pin_q && !nmi_pin) : (!pin_q && nmi_pin));

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         pin_event_flag <= 1'b0;
      end else if (pin_edge) begin
         pin_event_flag <= 1'b1;
      end else if (pin_event_flag_clr) begin
         pin_event_flag <= 1'b0;
      end
   end

   // ----------------------------------------
   // NMI enables
   // ----------------------------------------
   wire nmi_accept_clr = (state == ST_ACCEPT) && (cnt == 3'd0) && (sel_level == 4'(LVL_NMI));

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         pin_event_irq_enable        <= 1'b0;
         osc_fault_irq_enable        <= 1'b0;
         access_violation_irq_enable <= 1'b0;
      end else if (nmi_accept_clr) begin
         // Hardware clear beats a software write in the same cycle
         pin_event_irq_enable        <= 1'b0;
         osc_fault_irq_enable        <= 1'b0;
         access_violation_irq_enable <= 1'b0;
      end else if (nmi_enable_we) begin
         pin_event_irq_enable        <= nmi_enable_wdata[0];
         osc_fault_irq_enable        <= nmi_enable_wdata[1];
         access_violation_irq_enable <= nmi_enable_wdata[2];
      end
   end

   // ----------------------------------------
   // Request gating and priority
   // ----------------------------------------
   always_comb begin
      pending = '0;
      pending[LVL_NMI] = (pin_event_flag && pin_event_irq_enable)
                      || (osc_fault_flag && osc_fault_irq_enable)
                      || (access_violation_flag && access_violation_irq_enable);
      pending[NUM_LEVELS-1] = 1'b0;
   end

   logic [13:0] pending_mask;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_MASKABLE; gi++) begin : g_mask
         if (gi == LVL_WDT) begin : g_wdt
            assign pending_mask[gi] = watchdog_event_flag && watchdog_irq_enable
                                      && global_irq_enable;
         end else begin : g_per
            assign pending_mask[gi] = irq_request[gi] && irq_enable[gi] && global_irq_enable;
         end
      end
   endgenerate

   wire  [15:0] pending_all = {pending[15:14], pending_mask};

   always_comb begin
      next_level  = 4'd0;
      any_pending = 1'b0;
      // Lowest first so the highest index overwrites
      for (int i = 0; i < NUM_LEVELS; i++) begin
         if (pending_all[i]) begin
            next_level  = 4'(i);
            any_pending = 1'b1;
         end
      end
   end

   // Return wins a shared boundary; the request waits for the next one
   assign take = (state == ST_RUN) && instr_boundary && any_pending
                 && !return_from_service_instr;

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         state     <= ST_RUN;
         cnt       <= 3'd0;
         sel_level <= 4'd0;
      end else begin
         case (state)
            ST_RUN: begin
               cnt <= 3'd0;
               if (take) begin
                  state     <= ST_ACCEPT;
                  sel_level <= next_level;
               end else if (instr_boundary && return_from_service_instr) begin
                  state <= ST_RETURN;
               end
            end
            ST_ACCEPT: begin
               if (cnt == ACCEPT_CYCLES - 3'd1) begin
                  state <= ST_RUN;
                  cnt   <= 3'd0;
               end else begin
                  cnt <= cnt + 3'd1;
               end
            end
            ST_RETURN: begin
               if (cnt == RETURN_CYCLES - 3'd1) begin
                  state <= ST_RUN;
                  cnt   <= 3'd0;
               end else begin
                  cnt <= cnt + 3'd1;
               end
            end
            default: begin
               state <= ST_RUN;
               cnt   <= 3'd0;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Sequence strobes
   // ----------------------------------------
   wire in_acc = (state == ST_ACCEPT);
   wire in_ret = (state == ST_RETURN);

   always_comb begin
      stack_push        = in_acc && (cnt == 3'd1 || cnt == 3'd2);
      stack_pop         = in_ret && (cnt == 3'd1 || cnt == 3'd2);
      vector_fetch      = in_acc && (cnt == 3'd4);
      irq_ack           = in_acc && (cnt == 3'd0);
      irq_clear         = '0;
      watchdog_flag_clr = 1'b0;
      if (irq_ack && sel_level < 4'(NUM_MASKABLE)) begin
         if (sel_level == 4'(LVL_WDT)) begin
            watchdog_flag_clr = 1'b1;
         end else begin
            irq_clear[sel_level] = 1'b1;
         end
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         vector_addr <= VEC_RESET;
      end else if (take) begin
         vector_addr <= VEC_BASE + {11'd0, next_level, 1'b0};
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         stack_wdata <= 16'h0000;
      end else if (in_acc && cnt == 3'd0) begin
         stack_wdata <= next_instr_pc;
      end else if (in_acc && cnt == 3'd1) begin
         stack_wdata <= processor_status_word;
      end
   end

   // ----------------------------------------
   // Status word and program counter
   // ----------------------------------------
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         processor_status_word <= PSW_RESET;
      end else if (in_acc && cnt == 3'd3) begin
         processor_status_word <= processor_status_word & (16'h0001 << PSW_CLOCK_GATE_ZERO_BIT);
      end else if (in_ret && cnt == 3'd2) begin
         processor_status_word <= stack_rdata;
      end else if (psw_we && !busy) begin
         processor_status_word <= psw_wdata;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         pc      <= PC_RESET;
         pc_load <= 1'b0;
      end else begin
         pc_load <= 1'b0;
         if (in_acc && cnt == 3'd5) begin
            pc      <= vector_rdata;
            pc_load <= 1'b1;
         end else if (in_ret && cnt == 3'd3) begin
            pc      <= stack_rdata;
            pc_load <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   accept_len_a: assert property (@(posedge mclk) disable iff (!rstn)
      take |=> in_acc [*6] ##1 !in_acc)
      else $error("acceptance not six cycles");
   return_len_a: assert property (@(posedge mclk) disable iff (!rstn)
      (state == ST_RUN && instr_boundary && return_from_service_instr && !take)
      |=> in_ret [*5] ##1 !in_ret)
      else $error("return not five cycles");
   nmi_clear_a: assert property (@(posedge mclk) disable iff (!rstn)
      nmi_accept_clr |=> !pin_event_irq_enable && !osc_fault_irq_enable
                         && !access_violation_irq_enable)
      else $error("nmi enables not cleared");
   gie_block_a: assert property (@(posedge mclk) disable iff (!rstn)
      (take && !global_irq_enable) |-> next_level == 4'(LVL_NMI))
      else $error("maskable taken with global off");
   boundary_a: assert property (@(posedge mclk) disable iff (!rstn)
      $rose(in_acc) |-> $past(instr_boundary))
      else $error("taken off boundary");
   psw_clear_a: assert property (@(posedge mclk) disable iff (!rstn)
      (in_acc && cnt == 3'd3) |=> processor_status_word
         == ($past(processor_status_word) & (16'h0001 << PSW_CLOCK_GATE_ZERO_BIT)))
      else $error("status word not cleared");
   push_order_a: assert property (@(posedge mclk) disable iff (!rstn)
      (in_acc && cnt == 3'd0) |=> stack_push && stack_wdata == $past(next_instr_pc))
      else $error("pc not pushed first");
   vec_load_a: assert property (@(posedge mclk) disable iff (!rstn)
      (in_acc && cnt == 3'd5) |=> pc_load && pc == $past(vector_rdata))
      else $error("vector not loaded");
   pin_flag_a: assert property (@(posedge mclk) disable iff (!rstn)
      pin_edge |=> pin_event_flag)
      else $error("pin edge lost");
   wdt_vec_a: assert property (@(posedge mclk) disable iff (!rstn)
      (take && next_level == 4'(LVL_WDT)) |=> vector_addr == VEC_WDT)
      else $error("watchdog vector wrong");
   psw_restore_a: assert property (@(posedge mclk) disable iff (!rstn)
      (in_ret && cnt == 3'd2) |=> processor_status_word == $past(stack_rdata))
      else $error("status word not restored");
   ret_pc_a: assert property (@(posedge mclk) disable iff (!rstn)
      (in_ret && cnt == 3'd3) |=> pc_load && pc == $past(stack_rdata))
      else $error("return pc not loaded");

   nmi_take_c: cover property (@(posedge mclk) disable iff (!rstn) nmi_accept_clr);
   mask_take_c: cover property (@(posedge mclk) disable iff (!rstn)
      take && next_level < 4'(NUM_MASKABLE));
   ret_c: cover property (@(posedge mclk) disable iff (!rstn) $rose(in_ret));
   wdt_take_c: cover property (@(posedge mclk) disable iff (!rstn) watchdog_flag_clr);
   nest_c: cover property (@(posedge mclk) disable iff (!rstn)
      $fell(in_acc) ##[1:20] take);
endmodule

// [dv/ciau_cpu_model.sv]
// CPU core stand-in: stack memory and vector table contents
`timescale 1ns/1ps
module ciau_cpu_model (
   input  wire logic        mclk,
   input  wire logic        rstn,
   input  wire logic        stack_push,
   input  wire logic        stack_pop,
   input  wire logic [15:0] stack_wdata,
   input  wire logic [15:0] vector_addr,
   output logic      [15:0] stack_rdata,
   output logic      [15:0] vector_rdata
);
   logic [15:0] mem [0:7];
   logic [2:0]  sp;

   // ----------------------------------------
   // Stack
   // ----------------------------------------
   // Popped word stands in the cycle after each pop; otherwise inverted, so a
   // mistimed read never matches
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         sp          <= 3'd0;
         stack_rdata <= 16'h0000;
      end else if (stack_push) begin
         mem[sp]     <= stack_wdata;
         sp          <= sp + 3'd1;
         stack_rdata <= ~stack_rdata;
      end else if (stack_pop) begin
         sp          <= sp - 3'd1;
         stack_rdata <= mem[sp - 3'd1];
      end else begin
         stack_rdata <= ~stack_rdata;
      end
   end

   // ----------------------------------------
   // Vector table
   // ----------------------------------------
   // Each word holds 16'hc000 plus its offset in the table
   assign vector_rdata = {11'h600, vector_addr[4:0]};
endmodule

// [dv/test_ciau_top.sv]
// Self-checking testbench for the interrupt acceptance unit
`timescale 1ns/1ps
module test_ciau_top;
   import ciau_pkg::*;
   logic        mclk, rstn, watchdog_event_flag, watchdog_irq_enable, nmi_pin_mode, nmi_pin;
   logic        pin_edge_select_bit, osc_fault_flag, access_violation_flag, pin_event_flag_clr;
   logic        nmi_enable_we, instr_boundary, return_from_service_instr, psw_we;
   logic [13:0] irq_request, irq_enable, irq_clear;
   logic [2:0]  nmi_enable_wdata;
   logic [15:0] next_instr_pc, psw_wdata, stack_rdata, vector_rdata, processor_status_word;
   logic [15:0] pc, stack_wdata, vector_addr, clr_seen;
   logic        pc_load, stack_push, stack_pop, vector_fetch, irq_ack, watchdog_flag_clr, busy;
   logic        pin_event_flag, pin_event_irq_enable, osc_fault_irq_enable;
   logic        access_violation_irq_enable, global_irq_enable, wclr_seen;
   int          error_cnt, total_checks, busy_n, load_at, cycles, fetch_at, ack_at, pop_n;

   ciau_top dut (.mclk(mclk), .rstn(rstn), .irq_request(irq_request), .irq_enable(irq_enable),
      .watchdog_event_flag(watchdog_event_flag), .watchdog_irq_enable(watchdog_irq_enable),
      .nmi_pin_mode(nmi_pin_mode), .nmi_pin(nmi_pin), .pin_edge_select_bit(pin_edge_select_bit),
      .osc_fault_flag(osc_fault_flag), .access_violation_flag(access_violation_flag),
      .pin_event_flag_clr(pin_event_flag_clr), .nmi_enable_we(nmi_enable_we),
      .nmi_enable_wdata(nmi_enable_wdata), .instr_boundary(instr_boundary),
      .return_from_service_instr(return_from_service_instr), .next_instr_pc(next_instr_pc),
      .psw_we(psw_we), .psw_wdata(psw_wdata), .stack_rdata(stack_rdata),
      .vector_rdata(vector_rdata), .processor_status_word(processor_status_word), .pc(pc),
      .pc_load(pc_load), .stack_push(stack_push), .stack_pop(stack_pop),
      .stack_wdata(stack_wdata), .vector_fetch(vector_fetch), .vector_addr(vector_addr),
      .irq_ack(irq_ack), .irq_clear(irq_clear), .watchdog_flag_clr(watchdog_flag_clr),
      .busy(busy), .pin_event_flag(pin_event_flag), .pin_event_irq_enable(pin_event_irq_enable),
      .osc_fault_irq_enable(osc_fault_irq_enable),
      .access_violation_irq_enable(access_violation_irq_enable),
      .global_irq_enable(global_irq_enable));

   ciau_cpu_model mdl (.mclk(mclk), .rstn(rstn), .stack_push(stack_push), .stack_pop(stack_pop),
      .stack_wdata(stack_wdata), .vector_addr(vector_addr), .stack_rdata(stack_rdata),
      .vector_rdata(vector_rdata));

   // ----------------------------------------
   // Clock and hang guard
   // ----------------------------------------
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         error_cnt++;
         summarize();
      end
   end

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic set_psw(input logic [15:0] v);
      @(posedge mclk);
      psw_we    <= 1'b1;
      psw_wdata <= v;
      @(posedge mclk);
      psw_we    <= 1'b0;
   endtask

   task automatic set_nmi_en(input logic [2:0] v);
      @(posedge mclk);
      nmi_enable_we    <= 1'b1;
      nmi_enable_wdata <= v;
      @(posedge mclk);
      nmi_enable_we    <= 1'b0;
   endtask

   // Boundary pulse, then ten cycles of observation
   task automatic run(input logic ret);
      @(posedge mclk);
      instr_boundary            <= 1'b1;
      return_from_service_instr <= ret;
      @(posedge mclk);
      instr_boundary            <= 1'b0;
      return_from_service_instr <= 1'b0;
      busy_n = 0;
      load_at = 0;
      fetch_at = 0;
      ack_at = 0;
      pop_n = 0;
      clr_seen = '0;
      wclr_seen = 1'b0;
      for (int k = 1; k <= 10; k++) begin
         @(negedge mclk);
         if (busy === 1'b1) busy_n++;
         if (pc_load === 1'b1) load_at = k;
         if (vector_fetch === 1'b1) fetch_at = k;
         if (irq_ack === 1'b1) ack_at = k;
         if (stack_pop === 1'b1) pop_n++;
         clr_seen |= {2'b00, irq_clear};
         wclr_seen |= watchdog_flag_clr;
      end
      @(posedge mclk);
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      {rstn, watchdog_event_flag, watchdog_irq_enable, nmi_pin_mode, pin_edge_select_bit} = '0;
      {osc_fault_flag, access_violation_flag, pin_event_flag_clr, nmi_enable_we} = '0;
      {instr_boundary, return_from_service_instr, psw_we, nmi_enable_wdata} = '0;
      {irq_request, irq_enable, next_instr_pc, psw_wdata} = '0;
      nmi_pin = 1'b1;
      error_cnt = 0;
      total_checks = 0;
      cycles = 0;
      repeat (16) @(posedge mclk);
      rstn <= 1'b1;
      @(negedge mclk);
      chk("vector_addr", 16'hfffe, vector_addr);
      chk("psw", 16'h0000, processor_status_word);
      $display("test reset done");
      @(posedge mclk);

      irq_enable <= '1;
      irq_request <= 14'h0020;
      run(1'b0);
      chk("busy gie off", 16'h0000, 16'(busy_n));
      set_psw(16'h0058);
      irq_enable <= '0;
      run(1'b0);
      chk("busy ie off", 16'h0000, 16'(busy_n));
      irq_enable <= '1;
      watchdog_irq_enable <= 1'b1;
      repeat (6) @(negedge mclk);
      chk("busy no boundary", 16'h0000, {15'h0000, busy});
      $display("test masking done");
      @(posedge mclk);

      for (int l = 0; l < 14; l++) begin
         irq_request <= 14'((1 << (l + 1)) - 1);
         watchdog_event_flag <= (l >= 10);
         next_instr_pc <= 16'h1000 + 16'(l);
         set_psw(16'h0058);
         run(1'b0);
         chk("accept busy", 16'h0006, 16'(busy_n));
         chk("pc_load cycle", 16'h0007, 16'(load_at));
         chk("vector_addr", 16'hffe0 + 16'(2 * l), vector_addr);
         chk("pc vector", 16'hc000 + 16'(2 * l), pc);
         chk("irq_clear", (l == 10) ? 16'h0000 : 16'(1 << l), clr_seen);
         chk("wdt clear", {15'h0000, l == 10}, {15'h0000, wclr_seen});
         chk("pushed pc", 16'h1000 + 16'(l), mdl.mem[0]);
         chk("pushed psw", 16'h0058, mdl.mem[1]);
         chk("psw cleared", 16'h0040, processor_status_word);
         chk("gie cleared", 16'h0000, {15'h0000, global_irq_enable});
         chk("ack cycle", 16'h0001, 16'(ack_at));
         chk("fetch cycle", 16'h0005, 16'(fetch_at));
         set_psw(16'h0010);
         run(1'b1);
         chk("return busy", 16'h0005, 16'(busy_n));
         chk("psw restored", 16'h0058, processor_status_word);
         chk("pc restored", 16'h1000 + 16'(l), pc);
         chk("pop count", 16'h0002, 16'(pop_n));
         chk("gie restored", 16'h0001, {15'h0000, global_irq_enable});
      end
      {irq_request, watchdog_event_flag} <= '0;
      $display("test priority done");

      set_psw(16'h0000);
      set_nmi_en(3'b111);
      osc_fault_flag <= 1'b1;
      run(1'b0);
      chk("nmi busy", 16'h0006, 16'(busy_n));
      chk("nmi vector", 16'hfffc, vector_addr);
      chk("nmi no clear", 16'h0000, clr_seen);
      chk("nmi enables", 16'h0000, {13'h0000, access_violation_irq_enable,
          osc_fault_irq_enable, pin_event_irq_enable});
      osc_fault_flag <= 1'b0;
      run(1'b1);
      nmi_pin_mode <= 1'b1;
      pin_edge_select_bit <= 1'b1;
      repeat (2) @(posedge mclk);
      nmi_pin <= 1'b0;
      repeat (3) @(negedge mclk);
      chk("pin flag fall", 16'h0001, {15'h0000, pin_event_flag});
      run(1'b0);
      chk("pin no enable", 16'h0000, 16'(busy_n));
      @(posedge mclk);
      pin_event_flag_clr <= 1'b1;
      pin_edge_select_bit <= 1'b0;
      @(posedge mclk);
      pin_event_flag_clr <= 1'b0;
      set_nmi_en(3'b001);
      chk("pin flag cleared", 16'h0000, {15'h0000, pin_event_flag});
      nmi_pin <= 1'b1;
      repeat (3) @(negedge mclk);
      run(1'b0);
      chk("pin nmi vector", 16'hfffc, vector_addr);
      chk("pin flag kept", 16'h0001, {15'h0000, pin_event_flag});
      run(1'b1);
      $display("test nmi done");

      set_psw(16'h0008);
      irq_request <= 14'h0080;
      next_instr_pc <= 16'h2000;
      run(1'b0);
      irq_request <= 14'h0004;
      next_instr_pc <= 16'h3000;
      set_psw(16'h0008);
      run(1'b0);
      chk("nested busy", 16'h0006, 16'(busy_n));
      chk("nested pc", 16'hc004, pc);
      irq_request <= '0;
      run(1'b1);
      chk("inner return", 16'h3000, pc);
      run(1'b1);
      chk("outer return", 16'h2000, pc);
      chk("outer psw", 16'h0008, processor_status_word);
      $display("test nesting done");
      summarize();
   end
endmodule
